// File: rtl/psm_manager.sv
// Parameter store manager: card compare and copy, store mirror, reset commands
// What this block does
// RULE_01: At each power-up compare card contents with internal nonvolatile parameters.
// RULE_02: Every commit to nonvolatile storage is also written to the card; commitReq is dropped outside PSM_RUN or with an accepted command write.
// RULE_03: Empty card found at power-up receives the device parameters.
// RULE_04: Card from same fieldbus variant and size is loaded into the device.
// RULE_05: Card-loaded configuration takes effect only after a later power cycle.
// RULE_06: Card indicator stays off when no card is present or detected.
// RULE_07: Write-protected card is never written.
// RULE_08: User reset register: 0 does nothing, 65535 triggers; bit 0 restores defaults.
// RULE_09: User reset keeps communication, direction inversion and I/O function words.
// RULE_10: User reset values are not committed to nonvolatile storage.
// RULE_11: Both command writes accepted only while power stage disabled.
// RULE_12: User reset values become effective at next power stage enable.
// RULE_13: Entering state 2 after user reset defers values until power cycle.
// RULE_14: Writing 1 to factory restore loads defaults then commits them.
// RULE_15: Factory restore reads 0 once saving has finished.
// RULE_16: Restored factory defaults become active only at next power-up.
// RULE_17: Card copy carries fieldbus address and monitoring settings with the set.
// RULE_18: Failed detection, compare or transfer at power-up logs an error entry.
module psm_manager
    import psm_pkg::*;
(
    input  wire logic                  clk,            // System clock
    input  wire logic                  reset_n,        // Power-on reset, active low
    input  wire logic                  parWrite,       // Parameter write strobe
    input  wire logic                  parRead,        // Parameter read strobe
    input  wire logic [15:0]           parAddr,        // Parameter address
    input  wire logic [15:0]           parWdata,       // Parameter write data
    output logic      [15:0]           parRdata,       // Parameter read data
    output logic                       parReject,      // Write refused
    input  wire logic                  powerStageOn,   // Power stage enabled (pin)
    input  wire logic                  stateNotReady,  // Operating state 2 reached
    input  wire logic                  cardPresent,    // Card detected (pin)
    input  wire logic                  cardEmpty,      // Card holds no set
    input  wire logic                  cardCompatible, // Same fieldbus and size
    input  wire logic                  cardProtect,    // Card write-protected
    input  wire logic                  cardReadError,  // Card read failed
    input  wire logic [15:0]           cardRdata,      // Card word read
    output logic                       cardWe,         // Card word write
    output logic      [PSM_ADDR_W-1:0] cardAddr,       // Card word address
    output logic      [15:0]           cardWdata,      // Card write data
    output logic                       cardLed,        // Card indicator
    input  wire logic [15:0]           nvRdata,        // Nonvolatile word read
    output logic                       nvWe,           // Nonvolatile word write
    output logic      [PSM_ADDR_W-1:0] nvAddr,         // Nonvolatile word address
    output logic      [15:0]           nvWdata,        // Nonvolatile write data
    input  wire logic                  commitReq,      // Software commit of active set
    input  wire logic [15:0]           activeRdata,    // Active set word
    input  wire logic [15:0]           defaultRdata,   // Default value of word
    output logic                       pendingWe,      // Pending set write
    output logic      [PSM_ADDR_W-1:0] pendingAddr,    // Pending set address
    output logic      [15:0]           pendingWdata,   // Pending set data
    output logic                       applyOnEnable,  // Pending set loads at next enable
    output logic                       applyOnPowerUp, // Pending set loads at next power-up
    output logic                       errValid,       // Error memory entry
    output logic      [7:0]            errCode         // Error memory code
);
    // Pin synchronisers
    logic [1:0] pwrSync_q, presSync_q;
    logic [1:0] pwrSync_d, presSync_d;
    logic       pwrOn, present;

    always_comb begin
        pwrSync_d  = {pwrSync_q[0], powerStageOn};
        presSync_d = {presSync_q[0], cardPresent};
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwrSync_q  <= 2'h0;
            presSync_q <= 2'h0;
        end else begin
            pwrSync_q  <= pwrSync_d;
            presSync_q <= presSync_d;
        end
    end

    assign pwrOn   = pwrSync_q[1];
    assign present = presSync_q[1];

    // Word walker
    logic                  wClear, wStep, wLast;
    logic [PSM_ADDR_W-1:0] wIdx;

    psm_word_step u_step (
        .clk     (clk),
        .reset_n (reset_n),
        .clear   (wClear),
        .step    (wStep),
        .index   (wIdx),
        .last    (wLast)
    );

    // Control state
    psm_state_t state_q, state_d;
    logic [15:0] factory_q, factory_d;
    logic [15:0] user_q, user_d;
    logic        led_q, led_d;
    logic        apEn_q, apEn_d;
    logic        apPu_q, apPu_d;
    logic        err_q, err_d;
    logic [7:0]  code_q, code_d;
    logic        mismatch_q, mismatch_d;
    logic        keepWord;

    // Words a user reset must keep
    assign keepWord = (wIdx <= PSM_IO_LAST) && ((wIdx >= PSM_COMM_FIRST && wIdx <= PSM_COMM_LAST)
                      || wIdx == PSM_INVERT_WORD || wIdx >= PSM_IO_FIRST); // RULE_09

    // Next-state and datapath strobes
    always_comb begin
        state_d    = state_q;
        factory_d  = factory_q;
        user_d     = user_q;
        led_d      = led_q;
        apEn_d     = apEn_q;
        apPu_d     = apPu_q;
        err_d      = 1'b0;
        code_d     = code_q;
        mismatch_d = mismatch_q;
        wClear     = 1'b0;
        wStep      = 1'b0;
        cardWe     = 1'b0;
        cardWdata  = nvRdata;
        nvWe       = 1'b0;
        nvWdata    = defaultRdata;
        pendingWe  = 1'b0;
        pendingWdata = defaultRdata;
        parReject  = 1'b0;
        // Command writes, gated by the power stage
        if (parWrite && (parAddr == PSM_FACTORY_RESTORE_OFS || parAddr == PSM_USER_RESET_OFS)) begin
            if (pwrOn || state_q != PSM_RUN) begin
                parReject = 1'b1; // RULE_11
            end else if (parAddr == PSM_FACTORY_RESTORE_OFS) begin
                if (parWdata == PSM_FACTORY_GO) begin
                    factory_d = PSM_FACTORY_GO; // RULE_14
                    wClear    = 1'b1;
                    state_d   = PSM_FACT_RST;
                end else if (parWdata != PSM_FACTORY_NONE) begin
                    parReject = 1'b1;
                end
            end else begin
                if (parWdata == PSM_USER_RESET_GO) begin
                    user_d  = PSM_USER_RESET_GO; // RULE_08
                    wClear  = 1'b1;
                    state_d = PSM_USER_RST;
                end else if (parWdata != PSM_USER_RESET_NONE) begin
                    parReject = 1'b1; // RULE_08
                end
            end
        end
        // Deferred activation bookkeeping
        if (apEn_q && pwrOn) begin
            apEn_d = 1'b0; // RULE_12
        end
        if (apEn_q && stateNotReady) begin
            apEn_d = 1'b0;
            apPu_d = 1'b1; // RULE_13
        end
        case (state_q)
            PSM_IDLE: begin
                // Wait out the card detect synchroniser before deciding
                wClear     = (wIdx == PSM_ADDR_W'(PSM_SYNC_CYCLES));
                wStep      = 1'b1;
                mismatch_d = 1'b0;
                if (!wClear) begin
                    state_d = PSM_IDLE;
                end else if (!present) begin
                    led_d   = 1'b0; // RULE_06
                    state_d = PSM_RUN;
                end else if (cardReadError) begin
                    err_d   = 1'b1; // RULE_18
                    code_d  = PSM_ERR_CARD_READ;
                    state_d = PSM_RUN;
                end else if (cardEmpty) begin
                    led_d   = 1'b1;
                    state_d = cardProtect ? PSM_RUN : PSM_TO_CARD; // RULE_03
                end else begin
                    led_d   = 1'b1;
                    state_d = PSM_BOOT_CMP; // RULE_01
                end
            end
            PSM_BOOT_CMP: begin
                wStep = 1'b1;
                if (cardRdata != nvRdata) begin
                    mismatch_d = 1'b1; // RULE_01
                end
                if (wLast) begin
                    wClear = 1'b1;
                    if (!(mismatch_q || cardRdata != nvRdata)) begin
                        state_d = PSM_RUN;
                    end else if (cardCompatible) begin
                        state_d = PSM_FROM_CARD; // RULE_04
                    end else begin
                        err_d   = 1'b1; // RULE_18
                        code_d  = PSM_ERR_MISMATCH;
                        state_d = PSM_RUN;
                    end
                end
            end
            PSM_TO_CARD: begin
                cardWe    = 1'b1; // RULE_03
                cardWdata = nvRdata; // RULE_17
                wStep     = 1'b1;
                if (cardReadError) begin
                    err_d   = 1'b1; // RULE_18
                    code_d  = PSM_ERR_CARD_WRITE;
                    state_d = PSM_RUN;
                end else if (wLast) begin
                    state_d = PSM_RUN;
                end
            end
            PSM_FROM_CARD: begin
                nvWe    = 1'b1; // RULE_04
                nvWdata = cardRdata; // RULE_17
                wStep   = 1'b1;
                if (cardReadError) begin
                    err_d   = 1'b1; // RULE_18
                    code_d  = PSM_ERR_CARD_READ;
                    state_d = PSM_RUN;
                end else if (wLast) begin
                    apPu_d  = 1'b1; // RULE_05
                    state_d = PSM_RUN;
                end
            end
            PSM_USER_RST: begin
                // Defaults go to the pending set only, never to storage
                pendingWe    = user_q[PSM_USER_RESET_BIT] && !keepWord; // RULE_09 RULE_10
                pendingWdata = defaultRdata;
                wStep        = 1'b1;
                if (wLast) begin
                    user_d  = PSM_USER_RESET_NONE;
                    apEn_d  = 1'b1; // RULE_12
                    state_d = PSM_RUN;
                end
            end
            PSM_FACT_RST: begin
                nvWe    = 1'b1; // RULE_14
                nvWdata = defaultRdata;
                wStep   = 1'b1;
                if (wLast) begin
                    wClear  = 1'b1;
                    state_d = PSM_SAVE;
                end
            end
            PSM_SAVE, PSM_WAIT_STORE: begin
                // Mirror the committed set to the card
                cardWe    = present && !cardProtect; // RULE_02 RULE_07
                cardWdata = nvRdata;
                wStep     = 1'b1;
                if (wLast) begin
                    if (state_q == PSM_SAVE) begin
                        factory_d = PSM_FACTORY_NONE; // RULE_15
                        apPu_d    = 1'b1; // RULE_16
                    end
                    state_d = PSM_RUN;
                end
            end
            PSM_RUN: begin
                led_d = present; // RULE_06
                if (commitReq && state_d == PSM_RUN) begin
                    wClear  = 1'b1;
                    state_d = PSM_WAIT_STORE; // RULE_02
                end
            end
            default: begin
                state_d = PSM_IDLE;
            end
        endcase
    end

    // Control registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= PSM_IDLE;
            factory_q  <= PSM_REG_RESET;
            user_q     <= PSM_REG_RESET;
            led_q      <= 1'b0;
            apEn_q     <= 1'b0;
            apPu_q     <= 1'b0;
            err_q      <= 1'b0;
            code_q     <= PSM_ERR_RESET;
            mismatch_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            factory_q  <= factory_d;
            user_q     <= user_d;
            led_q      <= led_d;
            apEn_q     <= apEn_d;
            apPu_q     <= apPu_d;
            err_q      <= err_d;
            code_q     <= code_d;
            mismatch_q <= mismatch_d;
        end
    end

    // Read data register
    logic [15:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (parRead) begin
            case (parAddr)
                PSM_FACTORY_RESTORE_OFS: rdata_d = factory_q; // RULE_15
                PSM_USER_RESET_OFS:      rdata_d = user_q;
                default:                 rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign parRdata       = rdata_q;
    assign cardAddr       = wIdx;
    assign nvAddr         = wIdx;
    assign pendingAddr    = wIdx;
    assign cardLed        = led_q;
    assign applyOnEnable  = apEn_q;
    assign applyOnPowerUp = apPu_q;
    assign errValid       = err_q;
    assign errCode        = code_q;

    // activeRdata is the source for software commits held by the store itself
    logic unusedActive;
    assign unusedActive = ^activeRdata;
endmodule

// File: rtl/psm_pkg.sv
// Package with register offsets, field positions, reset values and state codes
package psm_pkg;
    // Register offsets on the parameter access port
    localparam logic [15:0] PSM_FACTORY_RESTORE_OFS = 16'h0404;
    localparam logic [15:0] PSM_USER_RESET_OFS      = 16'h0410;
    // Command values
    localparam logic [15:0] PSM_USER_RESET_NONE     = 16'h0000;
    localparam logic [15:0] PSM_USER_RESET_GO       = 16'hFFFF;
    localparam logic [15:0] PSM_FACTORY_NONE        = 16'h0000;
    localparam logic [15:0] PSM_FACTORY_GO          = 16'h0001;
    // Field positions
    localparam int PSM_USER_RESET_BIT = 0;
    // Cycles for the card detect synchroniser to fill after reset
    localparam int PSM_SYNC_CYCLES = 2;
    // Parameter store geometry
    localparam int PSM_ADDR_W = 6;
    localparam int PSM_WORDS  = 64;
    // Words of the parameter set that a user reset keeps
    localparam logic [5:0] PSM_COMM_FIRST  = 6'h00;
    localparam logic [5:0] PSM_COMM_LAST   = 6'h07;
    localparam logic [5:0] PSM_INVERT_WORD = 6'h08;
    localparam logic [5:0] PSM_IO_FIRST    = 6'h09;
    localparam logic [5:0] PSM_IO_LAST     = 6'h0F;
    // Reset values
    localparam logic [15:0] PSM_REG_RESET  = 16'h0000;
    localparam logic [7:0]  PSM_ERR_RESET  = 8'h00;
    // Error memory codes
    localparam logic [7:0] PSM_ERR_CARD_READ  = 8'h01;
    localparam logic [7:0] PSM_ERR_CARD_WRITE = 8'h02;
    localparam logic [7:0] PSM_ERR_MISMATCH   = 8'h03;

    typedef enum logic [3:0] {
        PSM_IDLE       = 4'h0,
        PSM_BOOT_CMP   = 4'h1,
        PSM_TO_CARD    = 4'h2,
        PSM_FROM_CARD  = 4'h3,
        PSM_RUN        = 4'h4,
        PSM_USER_RST   = 4'h5,
        PSM_FACT_RST   = 4'h6,
        PSM_SAVE       = 4'h7,
        PSM_WAIT_STORE = 4'h8
    } psm_state_t;
endpackage

// File: rtl/psm_word_step.sv
// Word counter that walks the parameter store and reports the last word
module psm_word_step
    import psm_pkg::*;
(
    input  wire logic                  clk,     // System clock
    input  wire logic                  reset_n, // Async reset, active low
    input  wire logic                  clear,   // Restart at word 0
    input  wire logic                  step,    // Advance one word
    output logic      [PSM_ADDR_W-1:0] index,   // Current word
    output logic                       last     // Current word is the final one
);
    logic [PSM_ADDR_W-1:0] index_q;
    logic [PSM_ADDR_W-1:0] index_d;

    // Next index
    always_comb begin
        index_d = index_q;
        if (clear) begin
            index_d = '0;
        end else if (step) begin
            index_d = index_q + 1'b1;
        end
    end

    // Index register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            index_q <= '0;
        end else begin
            index_q <= index_d;
        end
    end

    assign index = index_q;
    assign last  = (index_q == PSM_ADDR_W'(PSM_WORDS - 1));
endmodule

// File: verif/psm_card_model.sv
// Removable parameter card model: word memory, status flags, protect
module psm_card_model
    import psm_pkg::*;
(
    input  wire logic                  clk,            // System clock
    input  wire logic                  cfgPresent,     // Card inserted
    input  wire logic                  cfgFilled,      // Card holds a set
    input  wire logic                  cfgCompat,      // Same variant and size
    input  wire logic                  cfgProtect,     // Protect attribute set
    input  wire logic                  cardWe,         // Word write
    input  wire logic [PSM_ADDR_W-1:0] cardAddr,       // Word address
    input  wire logic [15:0]           cardWdata,      // Write data
    output logic      [15:0]           cardRdata,      // Read data
    output logic                       cardPresent,    // Detected
    output logic                       cardEmpty,      // No set stored
    output logic                       cardCompatible, // Set may be loaded
    output logic                       cardProtect,    // Writes forbidden
    output int                         cardCnt         // Writes seen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [PSM_WORDS];
    initial begin
        cardCnt = 0;
        for (int i = 0; i < PSM_WORDS; i++) mem[i] = 16'hC000 + 16'(i);
    end
    // Status flags seen at power-up
    assign cardPresent    = cfgPresent;
    assign cardEmpty      = cfgPresent & ~cfgFilled;
    assign cardCompatible = cfgPresent & cfgCompat;
    assign cardProtect    = cfgPresent & cfgProtect;
    // Absent card returns a pattern that moves with the address
    assign cardRdata = cfgPresent ? mem[cardAddr] : {10'h2A5, ~cardAddr};
    // Protected or absent card keeps its contents
    always @(posedge clk) begin
        if (cardWe) begin
            cardCnt <= cardCnt + 1;
            if (cfgPresent && !cfgProtect) mem[cardAddr] <= cardWdata;
        end
    end
endmodule

// File: verif/psm_manager_chk.sv
// Port checker for the parameter store manager
module psm_manager_chk
    import psm_pkg::*;
(
    input wire logic                  clk,          // Clock
    input wire logic                  reset_n,      // Reset
    input wire logic                  parWrite,     // Write strobe
    input wire logic [15:0]           parAddr,      // Address
    input wire logic [15:0]           parWdata,     // Write data
    input wire logic                  parReject,    // Refusal
    input wire logic                  powerStageOn, // Power stage
    input wire logic                  cardPresent,  // Card in
    input wire logic                  cardProtect,  // Protected
    input wire logic                  cardWe,       // Card write
    input wire logic [15:0]           cardWdata,    // Card data
    input wire logic                  cardLed,      // Indicator
    input wire logic [15:0]           nvRdata,      // Store data
    input wire logic                  nvWe,         // Store write
    input wire logic                  pendingWe,    // Pending write
    input wire logic [PSM_ADDR_W-1:0] pendingAddr,  // Pending word
    input wire logic                  applyOnEnable // Apply at enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Command writes by register
    wire isUser = parWrite && parAddr == PSM_USER_RESET_OFS;
    wire isFact = parWrite && parAddr == PSM_FACTORY_RESTORE_OFS;
    sequence s_user_go;
        isUser && parWdata == PSM_USER_RESET_GO && !parReject;
    endsequence
    sequence s_fact_go;
        isFact && parWdata == PSM_FACTORY_GO && !parReject;
    endsequence
    AST_LED_OFF: assert property (!cardPresent [*4] |-> !cardLed)
        else $error("indicator lit without card");
    AST_PROTECT: assert property (cardProtect |-> !cardWe)
        else $error("protected card written");
    AST_REJECT_POWER: assert property (powerStageOn [*4] ##0 (isUser || isFact) |-> parReject)
        else $error("command taken with power stage on");
    AST_USER_VALUE: assert property (isUser && !(parWdata inside {16'h0000, 16'hFFFF}) |-> parReject)
        else $error("illegal user reset value taken");
    AST_FACT_VALUE: assert property (isFact && parWdata > PSM_FACTORY_GO |-> parReject)
        else $error("illegal factory value taken");
    AST_USER_NO_NV: assert property (s_user_go |=> !nvWe [*8])
        else $error("user reset committed to store");
    AST_USER_KEEP: assert property (pendingWe |-> pendingAddr > PSM_IO_LAST)
        else $error("kept word overwritten");
    AST_FACT_SAVE: assert property (s_fact_go |-> ##[1:3] nvWe)
        else $error("factory restore not saved");
    AST_USER_APPLY: assert property (s_user_go |-> ##[1:100] applyOnEnable)
        else $error("user reset not armed for enable");
    AST_CARD_COPY: assert property (cardWe |-> cardWdata == nvRdata)
        else $error("card data differs from store");
endmodule

bind psm_manager psm_manager_chk u_psm_manager_chk (.*);

// File: verif/tb_psm_manager.sv
// Testbench for the parameter store manager with card partner
module tb_psm_manager
    import psm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset_n, parWrite, parRead, powerStageOn, stateNotReady, commitReq;
    logic cfgPresent, cfgFilled, cfgCompat, cfgProtect, parReject, cardPresent, cardEmpty;
    logic cardCompatible, cardProtect, cardWe, cardLed, nvWe, pendingWe, applyOnEnable;
    logic applyOnPowerUp, errValid;
    logic [15:0] parAddr, parWdata, parRdata, cardRdata, cardWdata, nvWdata, pendingWdata, nvRdata;
    logic [PSM_ADDR_W-1:0] cardAddr, nvAddr, pendingAddr;
    logic [7:0] errCode, lastErr;
    logic [15:0] nvMem [PSM_WORDS];
    int nvCnt, pendCnt, cardCnt, nErrors, compares;

    psm_manager u_psm_manager (.*, .cardReadError(1'b0), .activeRdata(16'h0000), .defaultRdata(16'h5A00));
    psm_card_model u_psm_card_model (.*);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Nonvolatile store, write counters, error capture
    assign nvRdata = nvMem[nvAddr];
    always @(posedge clk) begin
        if (nvWe) begin
            nvMem[nvAddr] <= nvWdata;
            nvCnt <= nvCnt + 1;
        end
        if (pendingWe) pendCnt <= pendCnt + 1;
        if (errValid) lastErr <= errCode;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic r);
        @(posedge clk);
        #1 parWrite = 1'b1;
        parAddr = a;
        parWdata = d;
        #20 r = parReject;
        cyc(1);
        parWrite = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge clk);
        #1 parRead = 1'b1;
        parAddr = a;
        cyc(1);
        parRead = 1'b0;
        #5 v = parRdata;
    endtask
    task automatic boot(input logic p, input logic f, input logic c, input logic w);
        cyc(1);
        reset_n = 1'b0;
        {cfgPresent, cfgFilled, cfgCompat, cfgProtect} = {p, f, c, w};
        lastErr = 8'h00;
        cyc(3);
        reset_n = 1'b1;
        cyc(160); // Sync plus a 64 word compare and a 64 word copy
    endtask
    task automatic t_boot_cases();
        int c0;
        boot(1'b1, 1'b1, 1'b1, 1'b0);
        check("load defer", {15'h0000, applyOnPowerUp}, 16'h0001);
        check("loaded word", nvMem[3], 16'hC003);
        nvMem[5] = 16'h0005;
        boot(1'b1, 1'b1, 1'b0, 1'b0);
        check("mismatch logged", {8'h00, lastErr}, {8'h00, PSM_ERR_MISMATCH});
        c0 = cardCnt;
        boot(1'b1, 1'b0, 1'b0, 1'b1);
        check("protected writes", 16'(cardCnt - c0), 16'h0000);
        boot(1'b0, 1'b0, 1'b0, 1'b0);
        check("indicator off", {15'h0000, cardLed}, 16'h0000);
        $display("boot cases done");
    endtask
    task automatic t_boot_empty();
        int c0;
        nvMem[0] = 16'h1234;
        nvMem[63] = 16'h4321;
        c0 = cardCnt;
        boot(1'b1, 1'b0, 1'b0, 1'b0);
        check("empty card writes", 16'(cardCnt - c0), 16'h0040);
        check("address word copied", u_psm_card_model.mem[0], 16'h1234);
        check("last word copied", u_psm_card_model.mem[63], 16'h4321);
        $display("empty card boot done");
    endtask
    task automatic t_user();
        logic r;
        int n0, p0;
        powerStageOn = 1'b1;
        cyc(4);
        wr(PSM_USER_RESET_OFS, PSM_USER_RESET_GO, r);
        check("user while on", {15'h0000, r}, 16'h0001);
        powerStageOn = 1'b0;
        cyc(4);
        wr(PSM_USER_RESET_OFS, 16'h0001, r);
        check("user bad value", {15'h0000, r}, 16'h0001);
        wr(PSM_USER_RESET_OFS, PSM_USER_RESET_NONE, r);
        check("user none", {15'h0000, r}, 16'h0000);
        n0 = nvCnt;
        p0 = pendCnt;
        wr(PSM_USER_RESET_OFS, PSM_USER_RESET_GO, r);
        check("user go", {15'h0000, r}, 16'h0000);
        cyc(100);
        check("reset words", 16'(pendCnt - p0), 16'h0030);
        check("no commit", 16'(nvCnt - n0), 16'h0000);
        check("apply at enable", {15'h0000, applyOnEnable}, 16'h0001);
        stateNotReady = 1'b1;
        cyc(4);
        check("state 2 defers", {15'h0000, applyOnPowerUp}, 16'h0001);
        stateNotReady = 1'b0;
        $display("user reset done");
    endtask
    task automatic t_factory();
        logic r;
        logic [15:0] v;
        int n0, c0, k;
        boot(1'b1, 1'b0, 1'b0, 1'b0);
        wr(PSM_FACTORY_RESTORE_OFS, 16'h0002, r);
        check("factory bad value", {15'h0000, r}, 16'h0001);
        n0 = nvCnt;
        c0 = cardCnt;
        wr(PSM_FACTORY_RESTORE_OFS, PSM_FACTORY_GO, r);
        check("factory go", {15'h0000, r}, 16'h0000);
        rd(PSM_FACTORY_RESTORE_OFS, v);
        check("busy reads one", v, 16'h0001);
        k = 0;
        do begin
            rd(PSM_FACTORY_RESTORE_OFS, v);
            k++;
        end while (v !== 16'h0000 && k < 300);
        if (k >= 300) begin
            nErrors++;
            $display("factory completion wait ran out");
            stop_test();
        end
        check("defaults saved", 16'(nvCnt - n0), 16'h0040);
        check("default word", nvMem[20], 16'h5A00);
        check("save mirrored", 16'(cardCnt - c0), 16'h0040);
        check("power-up apply", {15'h0000, applyOnPowerUp}, 16'h0001);
        $display("factory restore done");
    endtask
    task automatic t_commit();
        int c0;
        c0 = cardCnt;
        cyc(1);
        commitReq = 1'b1;
        cyc(1);
        commitReq = 1'b0;
        cyc(100);
        check("commit mirrored", 16'(cardCnt - c0), 16'h0040);
        $display("commit mirror done");
    endtask
    // Main sequence
    initial begin
        {reset_n, parWrite, parRead, powerStageOn, stateNotReady, commitReq} = 6'h00;
        {cfgPresent, cfgFilled, cfgCompat, cfgProtect} = 4'h0;
        parAddr = 16'h0000;
        parWdata = 16'h0000;
        lastErr = 8'h00;
        {nvCnt, pendCnt, nErrors, compares} = '0;
        for (int i = 0; i < PSM_WORDS; i++) nvMem[i] = 16'h1000 + 16'(i);
        cyc(20);
        reset_n = 1'b1;
        cyc(160);
        t_boot_cases();
        t_boot_empty();
        t_user();
        t_factory();
        t_commit();
        stop_test();
    end
endmodule
